// *** tb/ctrl_model.sv ***
// Controller model: mode pins, device clock and the shared serial line
module ctrl_model
    import eeword_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Pins toward the memory
    output logic dev_clk,
    output logic [2:0] mode,
    output logic io_line,
    // Memory line driver
    input wire logic io_out,
    input wire logic io_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic io_drv = 1'b0;
    logic io_en = 1'b0;
    logic last_q = 1'b0;

    initial begin
        dev_clk = 1'b1;
        mode = MODE_STANDBY;
    end

    // ==========================================================
    // Line level; a released line keeps changing, so stale data
    // can never pass for a driven bit
    assign io_line = !io_oe_n ? io_out : (io_en ? io_drv : !last_q);
    always @(posedge ref_clk) last_q <= io_line;

    // ==========================================================
    // One bit, line set half a period before the rising edge
    task automatic pulse(input logic b);
        @(posedge ref_clk);
        io_drv <= b;
        dev_clk <= 1'b0;
        repeat (8) @(posedge ref_clk);
        dev_clk <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask

    // Tens digit first, each one-hot, highest position first
    task automatic send_addr(input logic [19:0] v);
        mode <= MODE_ACCEPT_ADDR;
        io_en <= 1'b1;
        for (int i = 19; i >= 0; i--) pulse(v[i]);
    endtask

    task automatic send_data(input logic [13:0] v);
        mode <= MODE_ACCEPT_DATA;
        io_en <= 1'b1;
        for (int i = 13; i >= 0; i--) pulse(v[i]);
    endtask

    task automatic shift_out(input int n);
        mode <= MODE_SHIFT_OUT;
        io_en <= 1'b0;
        repeat (n) pulse(1'b0);
    endtask

    // Hold a mode for n cycles; clock runs, parks high when unused
    task automatic run(input logic [2:0] m, input int n);
        mode <= m;
        io_en <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            dev_clk <= m == MODE_UNUSED || !i[3] || i + 8 >= n;
        end
    endtask
endmodule

// *** tb/tb_serial_alterable_word_memory.sv ***
// Self-checking bench for the serial word memory
module tb_serial_alterable_word_memory
    import eeword_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG = 20;
    localparam int HOLD = 48;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic dev_clk;
    logic [2:0] mode;
    logic io_line;
    logic io_out;
    logic io_oe_n;
    int fails = 0;
    int total_checks = 0;
    int seed = 42167;
    logic exp_q[$];
    logic [19:0] av [4];
    logic [13:0] dv [4];
    logic [13:0] d;

    serial_alterable_word_memory #(
        .PROG_CYCLES(PROG)
    ) serial_alterable_word_memory_inst (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .dev_clk(dev_clk),
        .mode_select_bit1(mode[2]),
        .mode_select_bit2(mode[1]),
        .mode_select_bit3(mode[0]),
        .io_in(io_line),
        .io_out(io_out),
        .io_oe_n(io_oe_n)
    );

    ctrl_model ctrl_model_inst (
        .ref_clk(ref_clk),
        .dev_clk(dev_clk),
        .mode(mode),
        .io_line(io_line),
        .io_out(io_out),
        .io_oe_n(io_oe_n)
    );

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Checking
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Line holds the current bit at each rising edge of a shift
    always @(posedge dev_clk) begin
        if (mode == MODE_SHIFT_OUT) begin
            check(14'(io_oe_n), 14'h0000);
            check(14'(exp_q.size() > 0), 14'h0001);
            if (exp_q.size() > 0) begin
                check(14'(io_out), 14'(exp_q.pop_front()));
            end
        end
    end

    // ==========================================================
    // Operations
    function automatic logic [19:0] addr_of(input int a);
        return {10'h001 << (a / 10), 10'h001 << (a % 10)};
    endfunction

    task automatic expect_out(input logic [13:0] w);
        for (int i = 13; i >= 0; i--) exp_q.push_back(w[i]);
        ctrl_model_inst.shift_out(14);
    endtask

    task automatic read_shift(input logic [13:0] w);
        ctrl_model_inst.run(MODE_READ, HOLD);
        check(14'(io_oe_n), 14'h0001);
        expect_out(w);
    endtask

    // Erase first, then write, each held past the programming time
    task automatic prog(input logic [19:0] a, input logic [13:0] w);
        ctrl_model_inst.send_addr(a);
        ctrl_model_inst.run(MODE_ERASE, HOLD);
        ctrl_model_inst.send_data(w);
        ctrl_model_inst.run(MODE_WRITE, HOLD);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        av[0] = addr_of(0);
        av[1] = addr_of(99);
        av[2] = addr_of(1 + (($random(seed) & 'h7fff) % 49));
        av[3] = addr_of(50 + (($random(seed) & 'h7fff) % 49));
        foreach (dv[i]) begin
            dv[i] = 14'($random(seed));
            prog(av[i], dv[i]);
        end
        foreach (dv[i]) begin
            ctrl_model_inst.send_addr(av[i]);
            read_shift(dv[i]);
        end
        ctrl_model_inst.send_addr(av[0]);
        ctrl_model_inst.run(MODE_ERASE, HOLD);
        read_shift(ERASED_WORD);
        // Write abandoned before the programming time ends
        ctrl_model_inst.send_addr(av[1]);
        ctrl_model_inst.send_data(~dv[1]);
        ctrl_model_inst.run(MODE_WRITE, PROG / 2);
        read_shift(dv[1]);
        // Units digit with two bits set is no location at all
        prog({av[2][19:10], 10'h003}, ~dv[2]);
        read_shift(14'h0000);
        ctrl_model_inst.send_addr(av[2]);
        read_shift(dv[2]);
        ctrl_model_inst.run(MODE_STANDBY, 64);
        check(14'(io_oe_n), 14'h0001);
        ctrl_model_inst.run(MODE_UNUSED, 32);
        expect_out(dv[2]);
        ctrl_model_inst.run(MODE_UNUSED, 32);
        read_shift(dv[2]);
        d = 14'($random(seed));
        ctrl_model_inst.send_data(d);
        expect_out(d);
        ctrl_model_inst.run(MODE_STANDBY, 16);
        check(14'(exp_q.size()), 14'h0000);
        tally_and_finish();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
endmodule

// *** verilog/eeword_pkg.sv ***
// Constants shared by the serial word memory, its controller model and its bench
package eeword_pkg;
    // ==========================================================
    // Array geometry
    localparam int WORDS = 100;
    localparam int WORD_W = 14;
    localparam int DIGIT_W = 10;
    localparam int ADDR_SR_W = 2 * DIGIT_W;
    localparam int ADDR_W = 7;
    localparam logic [6:0] DIGIT_BASE = 7'h0a;
    localparam logic [13:0] ERASED_WORD = 14'h0000;
    localparam logic [13:0] WORD_RST = 14'h0000;

    // ==========================================================
    // Mode codes, bit 2 is mode_select_bit1
    localparam logic [2:0] MODE_WRITE = 3'h0;
    localparam logic [2:0] MODE_ACCEPT_DATA = 3'h1;
    localparam logic [2:0] MODE_SHIFT_OUT = 3'h2;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_ACCEPT_ADDR = 3'h4;
    localparam logic [2:0] MODE_ERASE = 3'h5;
    localparam logic [2:0] MODE_UNUSED = 3'h6;
    localparam logic [2:0] MODE_STANDBY = 3'h7;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int PROG_TIME_MS = 16;
    localparam int PROG_CYCLES_DEF =
        (PROG_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUF_DEPTH = 2;
endpackage

// *** verilog/serial_alterable_word_memory.sv ***
// Serial word-alterable nonvolatile memory, 100 words of 14 bits
// ==========================================================
module serial_alterable_word_memory
    import eeword_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Device clock and mode pins
    input wire logic dev_clk,
    input wire logic mode_select_bit1,
    input wire logic mode_select_bit2,
    input wire logic mode_select_bit3,
    // Serial data line
    input wire logic io_in,
    output logic io_out,
    output logic io_oe_n
);
    localparam int PCW = $clog2(PROG_CYCLES + 1);

    typedef struct packed {
        logic [2:0] clk_sync;
        logic [2:0] mode1;
        logic [2:0] mode2;
        logic [2:0] mode_prev;
        logic io1;
        logic io2;
        logic [ADDR_SR_W-1:0] addr_sr;
        logic [WORD_W-1:0] data;
        logic [WORDS-1:0][WORD_W-1:0] mem;
        logic [PCW-1:0] prog_cnt;
        logic prog_done;
        logic read_pend;
        logic oe_n;
    } state_s;

    // Edge sampler starts at the parked-high clock level: no false edge
    localparam state_s ST_RST = '{
        clk_sync: 3'h7,
        mode1: MODE_STANDBY,
        mode2: MODE_STANDBY,
        mode_prev: MODE_STANDBY,
        oe_n: 1'b1,
        default: '0
    };

    state_s q;
    state_s n;
    logic clk_rise;
    logic [2:0] mode;
    logic mode_chg;
    logic [4:0] tens;
    logic [4:0] units;
    logic addr_ok;
    logic [ADDR_W-1:0] addr;
    logic prog_fire;

    word_link_if #(.W(WORD_W)) push_if ();
    word_link_if #(.W(WORD_W)) pop_if ();

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // Address decode
    function automatic logic [4:0] onehot_idx(logic [DIGIT_W-1:0] v);
        logic [3:0] idx;
        logic [3:0] cnt;
        idx = '0;
        cnt = '0;
        for (int i = 0; i < DIGIT_W; i++) begin
            if (v[i]) begin
                idx = 4'(i);
                cnt = cnt + 4'h1;
            end
        end
        return {cnt == 4'h1, idx};
    endfunction

    // Malformed digits select nothing, so erase and write are skipped
    assign tens = onehot_idx(q.addr_sr[ADDR_SR_W-1:DIGIT_W]);
    assign units = onehot_idx(q.addr_sr[DIGIT_W-1:0]);
    assign addr_ok = tens[4] & units[4];
    assign addr = 7'({3'h0, tens[3:0]} * DIGIT_BASE)
        + 7'({3'h0, units[3:0]});

    addr_range_a: assert property (addr_ok |-> addr < 7'(WORDS))
        else $error("decoded address out of range");

    // ==========================================================
    // Mode and edge tracking
    assign clk_rise = q.clk_sync[1] & ~q.clk_sync[2];
    assign mode = q.mode2;
    assign mode_chg = (mode != q.mode_prev);
    assign prog_fire = !mode_chg && !q.prog_done
        && (q.prog_cnt == PCW'(PROG_CYCLES - 1));

    // ==========================================================
    // Read path through the buffer
    // A read that finds the buffer full waits instead of dropping a word
    assign push_if.valid = q.read_pend;
    assign push_if.data = addr_ok ? q.mem[addr] : ERASED_WORD;
    // Data register takes buffered words only in read mode
    assign pop_if.ready = (mode == MODE_READ);

    word_buffer #(.W(WORD_W), .DEPTH(BUF_DEPTH)) word_buffer_inst (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .push(push_if),
        .pop(pop_if)
    );

    // ==========================================================
    // Next state
    always_comb begin
        n = q;
        n.clk_sync = {q.clk_sync[1:0], dev_clk};
        n.mode1 = {mode_select_bit1, mode_select_bit2, mode_select_bit3};
        n.mode2 = q.mode1;
        n.io1 = io_in;
        n.io2 = q.io1;
        n.mode_prev = mode;
        n.oe_n = (mode != MODE_SHIFT_OUT);
        if (push_if.valid && push_if.ready) begin
            n.read_pend = 1'b0;
        end
        if (pop_if.valid && pop_if.ready) begin
            n.data = pop_if.data;
        end
        unique case (mode)
            MODE_ACCEPT_ADDR: begin
                if (clk_rise) begin
                    n.addr_sr = {q.addr_sr[ADDR_SR_W-2:0], q.io2};
                end
            end
            MODE_ACCEPT_DATA: begin
                if (clk_rise) begin
                    n.data = {q.data[WORD_W-2:0], q.io2};
                end
            end
            MODE_SHIFT_OUT: begin
                // Rotating keeps the word so it can be shifted out again
                if (clk_rise) begin
                    n.data = {q.data[WORD_W-2:0], q.data[WORD_W-1]};
                end
            end
            MODE_READ: begin
                if (mode_chg) begin
                    n.read_pend = 1'b1;
                end
            end
            MODE_ERASE, MODE_WRITE: begin
                // Leaving the mode early aborts; the word stays untouched
                if (mode_chg) begin
                    n.prog_cnt = '0;
                    n.prog_done = 1'b0;
                end else if (!q.prog_done) begin
                    n.prog_cnt = q.prog_cnt + PCW'(1);
                    if (prog_fire) begin
                        n.prog_done = 1'b1;
                        if (addr_ok && mode == MODE_ERASE) begin
                            n.mem[addr] = ERASED_WORD;
                        end
                        if (addr_ok && mode == MODE_WRITE) begin
                            n.mem[addr] = q.data;
                        end
                    end
                end
            end
            MODE_STANDBY, MODE_UNUSED: begin
                // Registers hold; the driver stays off
                // A pending read still pushes its word, and only once
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= ST_RST;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // Pin outputs
    assign io_out = q.data[WORD_W-1];
    assign io_oe_n = q.oe_n;

    // ==========================================================
    // Checks
    // Array and registers move only in the modes that own them
    standby_hold_a: assert property (
        (mode == MODE_STANDBY || mode == MODE_UNUSED) && !pop_if.valid
        |=> $stable(q.data) && $stable(q.addr_sr))
        else $error("standby changed a register");

    standby_float_a: assert property (
        mode == MODE_STANDBY [*2] |-> io_oe_n)
        else $error("driver on during standby");

    line_float_a: assert property (
        mode != MODE_SHIFT_OUT |=> io_oe_n)
        else $error("driver on outside shift out");

    shift_drive_a: assert property (
        mode == MODE_SHIFT_OUT |=> !io_oe_n && io_out == q.data[WORD_W-1])
        else $error("driver off during shift out");

    shift_out_a: assert property (
        mode == MODE_SHIFT_OUT && clk_rise
        |=> q.data == {$past(q.data[WORD_W-2:0]), $past(q.data[13])})
        else $error("shift out did not advance");

    addr_shift_a: assert property (
        mode == MODE_ACCEPT_ADDR && clk_rise
        |=> q.addr_sr == {$past(q.addr_sr[ADDR_SR_W-2:0]), $past(q.io2)})
        else $error("address bit not taken");

    data_shift_a: assert property (
        mode == MODE_ACCEPT_DATA && clk_rise
        |=> q.data == {$past(q.data[WORD_W-2:0]), $past(q.io2)})
        else $error("data bit not taken");

    read_load_a: assert property (
        pop_if.valid && pop_if.ready |=> q.data == $past(pop_if.data))
        else $error("read word not loaded");

    read_reach_a: assert property (
        mode == MODE_READ && mode_chg |-> ##[1:6] push_if.valid
        || $past(push_if.valid))
        else $error("read request not issued");

    erase_word_a: assert property (
        mode == MODE_ERASE && prog_fire && addr_ok
        |=> q.mem[$past(addr)] == ERASED_WORD)
        else $error("erase left bits set");

    write_word_a: assert property (
        mode == MODE_WRITE && prog_fire && addr_ok
        |=> q.mem[$past(addr)] == $past(q.data))
        else $error("write did not store data");

    prog_once_a: assert property (
        q.prog_done && !mode_chg |=> $stable(q.mem) || mode_chg)
        else $error("array changed twice in one hold");

    bad_addr_a: assert property (
        !addr_ok && prog_fire
        |=> $stable(q.mem))
        else $error("malformed address changed the array");

    prog_entry_a: assert property (
        (mode == MODE_ERASE || mode == MODE_WRITE) && mode_chg
        |=> $stable(q.mem))
        else $error("array changed on entry to programming");

    mem_quiet_a: assert property (
        mode != MODE_ERASE && mode != MODE_WRITE
        |=> $stable(q.mem))
        else $error("array changed outside erase or write");

    addr_quiet_a: assert property (
        mode != MODE_ACCEPT_ADDR
        |=> $stable(q.addr_sr))
        else $error("address changed outside accept address");

    data_quiet_a: assert property (
        mode == MODE_ERASE || mode == MODE_WRITE || mode == MODE_ACCEPT_ADDR
        |=> $stable(q.data))
        else $error("data register changed while programming");

    read_push_a: assert property (
        push_if.valid && push_if.ready && !(mode == MODE_READ && mode_chg)
        |=> !push_if.valid)
        else $error("read word pushed twice");

    pulse_once_a: assert property (
        clk_rise
        |=> !clk_rise)
        else $error("one clock pulse acted twice");

    unused_float_a: assert property (
        mode == MODE_UNUSED [*2]
        |-> io_oe_n)
        else $error("driver on in unused mode");

    shift_keep_a: assert property (
        mode == MODE_SHIFT_OUT && !clk_rise
        |=> $stable(q.data))
        else $error("shift out moved without a pulse");
endmodule

// *** verilog/word_buffer.sv ***
// Two-entry word buffer with valid and ready on both sides
module word_buffer #(
    parameter int W = 14,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Filling side
    word_link_if.rx push,
    // Draining side
    word_link_if.tx pop
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
    } buf_s;

    buf_s q;
    buf_s n;
    logic do_push;
    logic do_pop;

    // ==========================================================
    // Handshakes
    assign push.ready = (q.cnt != (PW + 1)'(DEPTH));
    assign pop.valid = (q.cnt != '0);
    assign pop.data = q.mem[q.rd];
    assign do_push = push.valid & push.ready;
    assign do_pop = pop.valid & pop.ready;

    always_comb begin
        n = q;
        if (do_push) begin
            n.mem[q.wr] = push.data;
            n.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + PW'(1);
        end
        if (do_pop) begin
            n.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + PW'(1);
        end
        if (do_push && !do_pop) begin
            n.cnt = q.cnt + (PW + 1)'(1);
        end else if (do_pop && !do_push) begin
            n.cnt = q.cnt - (PW + 1)'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule

// *** verilog/word_link_if.sv ***
// Valid/ready word channel between the memory core and its buffer
interface word_link_if #(
    parameter int W = 14
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport tx (output valid, output data, input ready);
    modport rx (input valid, input data, output ready);
endinterface
